/* hdl/ssm_top.sv */
// Purpose: Spread spectrum modulator driving a PLL feedback divider
// Assumes: ref_clk is the detector clock; software keeps its own limits
// Notes: Two spread blocks exist on the map; the second is storage only here
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
module ssm_top
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [ssm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [ssm_pkg::DATA_W-1:0] reg_rdata,
  output logic [ssm_pkg::INT_W-1:0] int_count,
  output logic [ssm_pkg::ADJ_W-1:0] adjust_value,
  output logic [12:0] divide_count,
  output logic [ssm_pkg::OFFSET_W-1:0] frac_out,
  output logic [3:0] loop_resistor_code,
  output logic [3:0] zero_cap_code,
  output logic [3:0] pole_cap_code,
  output logic [2:0] pump_current_code
);
  import ssm_pkg::*;

  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
    return a[7:3] == base[7:3];
  endfunction

  logic [7:0] block0 [0:7];
  logic [7:0] block1 [0:7];
  logic [7:0] int_lo, int_hi, loop_a, loop_b;
  logic [6:0] frac_acc;
  logic rnd_bit;
  ssm_cfg_if cfg ();

  wire sel0 = in_block(reg_addr, PLL0_BASE);
  wire sel1 = in_block(reg_addr, PLL1_BASE);
  wire [2:0] sub = reg_addr[2:0];

  // Register writes
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        block0[i] <= RESET_VAL;
        block1[i] <= RESET_VAL;
      end
      int_lo <= RESET_VAL;
      int_hi <= RESET_VAL;
      loop_a <= RESET_VAL;
      loop_b <= RESET_VAL;
    end
    else if (clk_en && reg_write)
    begin
      if (sel0) block0[sub] <= reg_wdata;
      if (sel1) block1[sub] <= reg_wdata;
      if (reg_addr == INT_LO) int_lo <= reg_wdata;
      if (reg_addr == INT_HI) int_hi <= reg_wdata;
      if (reg_addr == LOOP_A) loop_a <= reg_wdata;
      if (reg_addr == LOOP_B) loop_b <= {1'b0, reg_wdata[6:0]};
    end
  end

  // Read mux, answered one cycle later; unmapped reads zero
  wire [7:0] status_word = {1'b0, cfg.active, cfg.step_value};
  wire [7:0] rd_mux =
    sel0 ? block0[sub] :
    sel1 ? block1[sub] :
    reg_addr == INT_LO ? int_lo :
    reg_addr == INT_HI ? int_hi :
    reg_addr == LOOP_A ? loop_a :
    reg_addr == LOOP_B ? loop_b :
    reg_addr == STATUS ? status_word :
    reg_addr == CNT_LO ? divide_count[7:0] : 8'h00;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= RESET_VAL;
    else if (clk_en)
      reg_rdata <= reg_read ? rd_mux : 8'h00;
  end

  assign cfg.step_code = block0[OFS_TIMING][3:0];
  assign cfg.quad_code = block0[OFS_TIMING][7:4];
  assign cfg.frac_offset = block0[OFS_FRAC][5:0];
  assign cfg.random_lsb_enable = block0[OFS_FRAC][6];
  assign cfg.amplitude_double = block0[OFS_FRAC][7];
  assign cfg.delta_sample = {block0[7], block0[6], block0[5], block0[4], block0[3], block0[2]};

  ssm_lfsr u_lfsr (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .rnd_bit(rnd_bit)
  );

  ssm_engine u_engine (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .rnd_bit(rnd_bit),
    .cfg(cfg)
  );

  // Integer part 2N + A + 1; the fraction is carried in by the accumulator
  wire [11:0] n_val = {int_hi[3:0], int_lo};
  wire [3:0] a_val = int_hi[7:4];
  wire [12:0] int_part = 13'({n_val, 1'b0}) + 13'(a_val) + 13'h0001;
  wire [6:0] next_acc = 7'(frac_acc[5:0]) + 7'(cfg.step_value);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frac_acc <= 7'h00;
      divide_count <= 13'h0000;
      frac_out <= 6'h00;
    end
    else if (clk_en)
    begin
      frac_acc <= next_acc;
      frac_out <= cfg.step_value;
      divide_count <= int_part + 13'(next_acc[6]);
    end
  end

  assign int_count = n_val;
  assign adjust_value = a_val;
  assign loop_resistor_code = loop_a[3:0];
  assign zero_cap_code = loop_a[7:4];
  assign pole_cap_code = loop_b[3:0];
  assign pump_current_code = loop_b[6:4];

  a_carry_adds_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en ##1 clk_en |-> divide_count == int_part + 13'($past(next_acc[6])) || $changed(int_part))
    else $error("divide count not integer plus carry");
  a_read_latency: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_read && sel0 ##1 clk_en |-> reg_rdata == $past(block0[sub]))
    else $error("spread block read mismatch");
  a_frac_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en |=> frac_out == $past(cfg.step_value))
    else $error("fraction output stale");
  a_loop_fields: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_write && reg_addr == LOOP_B |=> pump_current_code == $past(reg_wdata[6:4]))
    else $error("pump code not stored");
endmodule // ssm_top

/* hdl/ssm_pkg.sv */
// Purpose: Shared constants and types for the spread spectrum modulator
// Assumes: Register port with one-cycle read latency, 8-bit data
// Notes: Offsets are byte addresses on the register port
package ssm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_SAMPLES = 12;
  localparam int SAMPLE_W = 4;
  localparam int OFFSET_W = 6;
  localparam int INT_W = 12;
  localparam int ADJ_W = 4;
  // Step period adds this to the code
  localparam logic [4:0] STEP_BIAS = 5'h02;
  // Spread block base addresses; only the PLL0 block drives the modulator, the PLL1 block is storage only
  localparam logic [7:0] PLL0_BASE = 8'h60;
  localparam logic [7:0] PLL1_BASE = 8'h68;
  // Offsets within a block of eight
  localparam logic [2:0] OFS_TIMING = 3'h0;  // [3:0] step code, [7:4] quadrant code
  localparam logic [2:0] OFS_FRAC = 3'h1;    // [5:0] offset, [6] random lsb, [7] double
  localparam logic [2:0] OFS_SAMP0 = 3'h2;   // Samples 0..11, two per byte, addr 2..7
  // Own registers outside the spread blocks
  localparam logic [7:0] INT_LO = 8'h70;     // Integer count [7:0]
  localparam logic [7:0] INT_HI = 8'h71;     // [3:0] integer count [11:8], [7:4] adjust
  localparam logic [7:0] LOOP_A = 8'h72;     // [3:0] resistor, [7:4] zero cap
  localparam logic [7:0] LOOP_B = 8'h73;     // [3:0] pole cap, [6:4] pump current
  localparam logic [7:0] STATUS = 8'h74;     // [5:0] current step value, [6] active
  localparam logic [7:0] CNT_LO = 8'h75;     // [7:0] divide count low byte (read only)
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [7:0] RESET_VAL = 8'h00;

  typedef enum logic [3:0] {
    SSM_IDLE = 4'h1,
    SSM_RISE = 4'h2,
    SSM_FALL = 4'h4,
    SSM_HOLD = 4'h8
  } ssm_state_t;
endpackage

/* hdl/ssm_cfg_if.sv */
// Purpose: Configuration bundle from register file to waveform engine
// Assumes: Single clock domain
// Notes: Samples flattened into one vector
interface ssm_cfg_if;
  logic [3:0] step_code;
  logic [3:0] quad_code;
  logic [5:0] frac_offset;
  logic random_lsb_enable;
  logic amplitude_double;
  logic [47:0] delta_sample;
  logic [5:0] step_value;
  logic active;
  modport regs (output step_code, quad_code, frac_offset, random_lsb_enable,
                amplitude_double, delta_sample, input step_value, active);
  modport eng (input step_code, quad_code, frac_offset, random_lsb_enable,
               amplitude_double, delta_sample, output step_value, active);
endinterface

/* hdl/ssm_lfsr.sv */
// Purpose: Free-running pseudo-random bit source
// Assumes: Detector clock
// Notes: 16-bit Fibonacci sequence, never locks at zero with this seed
module ssm_lfsr
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  output logic rnd_bit
);
  logic [15:0] lfsr;
  wire feedback = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10];

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      lfsr <= LFSR_SEED;
    else if (clk_en)
      lfsr <= {lfsr[14:0], feedback};
  end

  assign rnd_bit = lfsr[0];
endmodule // ssm_lfsr

/* hdl/ssm_engine.sv */
// Purpose: Quadrant waveform generator for one modulated PLL
// Assumes: Configuration held stable while active
// Notes: Produces step value in sixty-fourths
module ssm_engine
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic rnd_bit,
  ssm_cfg_if.eng cfg
);
  ssm_state_t state, next_state;
  logic [4:0] hold_cnt;
  logic [3:0] samp_idx;
  logic [6:0] accum;
  wire [4:0] step_len = 5'(cfg.step_code) + STEP_BIAS;
  wire [3:0] n_used = 4'({cfg.quad_code, 1'b0});
  wire step_done = hold_cnt == step_len - 5'h01;
  wire [3:0] cur_delta = cfg.delta_sample[samp_idx*4 +: 4];
  wire enabled = cfg.step_code != 4'h0;
  wire last_samp = samp_idx == n_used - 4'h1;
  wire [6:0] scaled = cfg.amplitude_double ? {accum[5:0], 1'b0} : accum;
  wire [6:0] base = 7'(cfg.frac_offset) + scaled;
  wire [6:0] dithered = base ^ {6'h00, cfg.random_lsb_enable & rnd_bit};

  always_comb
  begin
    next_state = state;
    unique case (state)
      SSM_IDLE: if (enabled) next_state = SSM_RISE;
      // Each rise or fall is one quadrant of n_used steps: 2 per period
      SSM_RISE: if (!enabled) next_state = SSM_IDLE;
        else if (step_done && last_samp) next_state = SSM_FALL;
      SSM_FALL: if (!enabled) next_state = SSM_IDLE;
        else if (step_done && samp_idx == 4'h0) next_state = SSM_RISE;
      default: next_state = SSM_IDLE;
    endcase
  end

  // Rise adds deltas, fall subtracts them in reverse. The fraction is unsigned,
  // so the two lower quadrants fold onto the upper pair instead of going below offset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= SSM_IDLE;
      hold_cnt <= 5'h00;
      samp_idx <= 4'h0;
      accum <= 7'h00;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (state == SSM_IDLE || !enabled)
      begin
        hold_cnt <= 5'h00;
        samp_idx <= 4'h0;
        accum <= 7'h00;
      end
      else if (step_done)
      begin
        hold_cnt <= 5'h00;
        if (state == SSM_RISE)
        begin
          accum <= accum + 7'(cur_delta);
          if (!last_samp) samp_idx <= samp_idx + 4'h1;
        end
        else if (state == SSM_FALL)
        begin
          accum <= accum - 7'(cur_delta);
          if (samp_idx != 4'h0) samp_idx <= samp_idx - 4'h1;
        end
      end
      else
        hold_cnt <= hold_cnt + 5'h01;
    end
  end

  // Deltas all zero leave accum at zero: static fraction unless the random lsb is on
  assign cfg.step_value = enabled ? dithered[5:0] : cfg.frac_offset;
  assign cfg.active = state != SSM_IDLE;

  a_hold_length: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && enabled && state != SSM_IDLE |-> hold_cnt < step_len)
    else $error("hold counter passed step length");
  a_peak_turn: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && enabled && state == SSM_RISE && step_done && last_samp |=> state == SSM_FALL)
    else $error("rise did not turn at last sample");
  a_disabled_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && !enabled |=> state == SSM_IDLE)
    else $error("modulator not idle when disabled");
  a_index_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state != SSM_IDLE && enabled |-> samp_idx < n_used)
    else $error("sample index beyond used count");
  a_static_frac: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg.delta_sample == 48'h0 && !cfg.random_lsb_enable |-> cfg.step_value == cfg.frac_offset)
    else $error("static fraction disturbed");
endmodule // ssm_engine

/* testbench/ssm_div_model.sv */
// Purpose: Feedback divider partner that totals VCO cycles per detector cycle
// Assumes: One divide count is consumed on every detector clock edge
// Notes: Totals are cleared by the bench before each measurement window
module ssm_div_model
(
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic [12:0] divide_count,
  output logic [31:0] vco_total
);
  timeunit 1ns;
  timeprecision 1ns;
  // Carries show up only as a longer total, so the sum is what counts
  always @(posedge ref_clk)
  begin
    if (clr)
      vco_total <= 32'h0;
    else
      vco_total <= vco_total + 32'(divide_count);
  end
endmodule // ssm_div_model

/* testbench/tb_spread_spectrum_modulator.sv */
// Purpose: Self-checking bench for the spread spectrum modulator
// Assumes: clk_en held high; software limits kept by the stimulus
// Notes: Profiles are judged from a trace of frac_out
module tb_spread_spectrum_modulator;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset_n, clk_en, reg_write, reg_read, clr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] int_count;
  logic [3:0] adjust_value, loop_resistor_code, zero_cap_code, pole_cap_code;
  logic [12:0] divide_count;
  logic [5:0] frac_out;
  logic [2:0] pump_current_code;
  logic [31:0] vco_total;
  logic [5:0] trace [0:199];
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int ones;

  ssm_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .int_count(int_count), .adjust_value(adjust_value), .divide_count(divide_count),
    .frac_out(frac_out), .loop_resistor_code(loop_resistor_code),
    .zero_cap_code(zero_cap_code), .pole_cap_code(pole_cap_code),
    .pump_current_code(pump_current_code));
  ssm_div_model partner (.ref_clk(ref_clk), .clr(clr), .divide_count(divide_count),
    .vco_total(vco_total));

  always #5 ref_clk = ~ref_clk;

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Expected cycle budget is about 1200, so this only trips on a hang
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Skips 10 start-up cycles, then traces 200 cycles, which need not be whole periods
  task automatic capture;
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge ref_clk);
      #1;
      trace[i] = frac_out;
    end
  endtask

  task automatic prof(input logic [5:0] lo, input logic [5:0] hi);
    logic [5:0] mx;
    logic [5:0] mn;
    int f;
    capture();
    mx = trace[0];
    mn = trace[0];
    f = -1;
    for (int i = 1; i < 200; i++)
    begin
      if (trace[i] > mx) mx = trace[i];
      if (trace[i] < mn) mn = trace[i];
      if (trace[i] !== trace[i-1])
      begin
        if (f < 0) f = i;
        else chk((i - f) % 7, 0);
      end
      if (i < 144) chk(trace[i], trace[i+56]);
    end
    chk(mx, hi);
    chk(mn, lo);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    clr = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h72, 8'h00);
    rd(8'h73, 8'h00);
    wr(8'h72, 8'h5a);
    wr(8'h73, 8'hff);
    rd(8'h72, 8'h5a);
    rd(8'h73, 8'h7f);
    chk({loop_resistor_code, zero_cap_code, pole_cap_code, pump_current_code},
        {4'ha, 4'h5, 4'hf, 3'h7});
    rd(8'h50, 8'h00);
    wr(8'h6a, 8'h93);
    rd(8'h6a, 8'h93);
    wr(8'h70, 8'h0f);
    wr(8'h71, 8'h20);
    wr(8'h62, 8'h53);
    wr(8'h63, 8'h01);
    rd(8'h62, 8'h53);
    rd(8'h63, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(int_count, 12'h00f);
    chk(adjust_value, 4'h2);
    chk(divide_count, 13'd33);
    rd(8'h75, 8'h21);
    prof(6'd0, 6'd0);
    wr(8'h60, 8'h15);
    prof(6'd0, 6'd8);
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h80);
    wr(8'h60, 8'h15);
    prof(6'd0, 6'd16);
    wr(8'h60, 8'h00);
    wr(8'h62, 8'h00);
    wr(8'h63, 8'h00);
    wr(8'h61, 8'h30);
    wr(8'h60, 8'h15);
    prof(6'd48, 6'd48);
    rd(8'h74, 8'h70);
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (64) @(posedge ref_clk);
    #1;
    chk(vco_total, 32'd2160);
    wr(8'h61, 8'h70);
    capture();
    ones = 0;
    for (int i = 0; i < 200; i++)
    begin
      chk(trace[i][5:1], 5'h18);
      ones += int'(trace[i][0]);
    end
    chk(ones > 0 && ones < 200, 1'b1);
    give_verdict();
  end
endmodule // tb_spread_spectrum_modulator
